//--- src/snv_pkg.sv
// constants, field positions and state codes for the two-wire nvram slave
package snv_pkg;

  // array geometry
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MEM_DEPTH = 512;
  localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 9'h001;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 9'h1FF;

  // slot counter within one byte frame: 0..7 data, 8 acknowledge
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;

  // slave address byte fields
  localparam int unsigned SA_RW = 0;
  localparam int unsigned SA_PAGE = 1;
  localparam int unsigned SA_CS_LO = 2;
  localparam int unsigned SA_CS_HI = 3;
  localparam int unsigned SA_TYPE_LSB = 4;
  localparam int unsigned SA_TYPE_W = 4;

  // pin synchroniser vector layout
  localparam int unsigned PIN_N = 5;
  localparam int unsigned PIN_SDA = 0;
  localparam int unsigned PIN_SCL = 1;
  localparam int unsigned PIN_CSL = 2;
  localparam int unsigned PIN_CSH = 3;
  localparam int unsigned PIN_WP = 4;
  // bus lines idle high, so a reset never fakes a start or stop
  localparam logic [PIN_N-1:0] PIN_RST = 5'h03;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SLAVE = 6'h02,
    ST_WORD = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ = 6'h10,
    ST_IGNORE = 6'h20
  } snv_state_t;

endpackage : snv_pkg

//--- src/snv_slave.sv
// two-wire serial slave front end with a 512 x 8 memory array
//
// Overview of operation
// [RULE_01] data rising while clock high is stop: ends and aborts everything
// [RULE_02] data falling while clock high is start: aborts, awaits new address
// [RULE_03] master issues stop only while it owns data, never during reads
// [RULE_04] data stays stable while clock high, except start and stop
// [RULE_05] ninth slot is acknowledge: transmitter releases, receiver pulls low
// [RULE_06] data left high in acknowledge slot aborts the transaction
// [RULE_07] reads continue while master acknowledges; master nacks final byte
// [RULE_08] first byte after start is slave address; upper nibble type must match
// [RULE_09] address bits 3 and 2 must equal high and low strap pins
// [RULE_10] address bit 1 selects the 256-byte half, address bit 8
// [RULE_11] address bit 0 is direction: zero write, one read
// [RULE_12] write sends low address byte; slave latches nine-bit address
// [RULE_13] read uses latched low byte with page bit from slave address
// [RULE_14] address latch advances after each data byte, before acknowledge
// [RULE_15] address wraps from highest location to zero, both directions
// [RULE_16] unlimited sequential bytes per transaction, no page boundary
// [RULE_17] read: drive eight bits, sample ack; ack continues, nack ends
// [RULE_18] write: receive eight bits, then drive acknowledge
// [RULE_19] every byte travels most significant bit first
// [RULE_20] array written at eighth bit; start or stop earlier discards byte
// [RULE_21] no busy period after writes; addressing always acknowledged
// [RULE_22] write protect high: array unchanged and data bytes not acknowledged
// [RULE_23] blocked data bytes do not advance the address counter
// [RULE_24] output shifts on falling clock edges, input captured on rising
// [RULE_25] address mismatch: data released, traffic ignored until next start
// [RULE_26] after reset: idle, data released, address latch at zero
module snv_slave #(
  // device type code; value is arbitrary
  parameter logic [3:0] DEV_TYPE = 4'h5
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // two-wire bus, clock also clocks the output stage
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // strap and protect pins
  input wire logic chip_select_strap_high,
  input wire logic chip_select_strap_low,
  input wire logic write_protect
);
  import snv_pkg::*;

  // pin synchronisers, the first stage is read by the second only
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_m_q;
  logic [PIN_N-1:0] pin_s_q;
  logic [PIN_N-1:0] pin_p_q;

  assign pin_raw = {write_protect, chip_select_strap_high,
                    chip_select_strap_low, scl, sda_i};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_m_q <= PIN_RST;
      pin_s_q <= PIN_RST;
      pin_p_q <= PIN_RST;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  logic sda_s;
  logic sda_p;
  logic scl_s;
  logic scl_p;
  logic csl_s;
  logic csh_s;
  logic wp_s;

  assign sda_s = pin_s_q[PIN_SDA];
  assign sda_p = pin_p_q[PIN_SDA];
  assign scl_s = pin_s_q[PIN_SCL];
  assign scl_p = pin_p_q[PIN_SCL];
  assign csl_s = pin_s_q[PIN_CSL];
  assign csh_s = pin_s_q[PIN_CSH];
  assign wp_s = pin_s_q[PIN_WP];

  // bus condition decode
  logic start_det;
  logic stop_det;
  logic rise_det;
  logic fall_det;

  assign start_det = scl_s & scl_p & sda_p & ~sda_s; // RULE_02
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s; // RULE_01
  assign rise_det = scl_s & ~scl_p;
  assign fall_det = ~scl_s & scl_p;

  // state and datapath registers
  snv_state_t st_q;
  snv_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [BYTE_W-1:0] rx_q;
  logic [BYTE_W-1:0] rx_d;
  logic [BYTE_W-1:0] tx_q;
  logic [BYTE_W-1:0] tx_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic rw_q;
  logic rw_d;
  logic ack_q;
  logic ack_d;
  logic drv_q;
  logic drv_d;
  logic primed_q;
  logic wr_en;

  logic [BYTE_W-1:0] mem [MEM_DEPTH];

  // decode and selection
  logic st_active;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] rd_word;
  logic [ADDR_W-1:0] addr_inc;
  logic [3:0] cnt_nxt;
  logic dev_match;
  logic at_last;
  logic at_ack;

  assign st_active = (st_q != ST_IDLE) && (st_q != ST_IGNORE);
  assign rx_byte = {rx_q[BYTE_W-2:0], sda_s}; // RULE_19 RULE_24
  assign rd_word = mem[addr_q];
  assign addr_inc = addr_q + ADDR_ONE; // RULE_15 RULE_16
  assign cnt_nxt = (cnt_q == CNT_ACK) ? CNT_ZERO : cnt_q + CNT_ONE;
  assign at_last = (cnt_q == CNT_LAST);
  assign at_ack = (cnt_q == CNT_ACK);
  assign dev_match =
    (rx_byte[SA_TYPE_LSB +: SA_TYPE_W] == DEV_TYPE) && // RULE_08
    (rx_byte[SA_CS_HI] == csh_s) && // RULE_09
    (rx_byte[SA_CS_LO] == csl_s); // RULE_09

  // drv_d set means the slave pulls the data line low in the coming low phase
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    addr_d = addr_q;
    rw_d = rw_q;
    ack_d = ack_q;
    drv_d = drv_q;
    wr_en = 1'b0;
    if (stop_det) begin
      st_d = ST_IDLE; // RULE_01
      drv_d = 1'b0;
    end else if (start_det) begin
      st_d = ST_SLAVE; // RULE_02
      cnt_d = CNT_ZERO;
      drv_d = 1'b0;
    end else if (rise_det && st_active) begin
      cnt_d = cnt_nxt;
      rx_d = rx_byte;
      drv_d = 1'b0;
      unique case (st_q)
        ST_SLAVE: begin
          if (at_last) begin
            if (dev_match) begin
              rw_d = rx_byte[SA_RW]; // RULE_11
              addr_d = {rx_byte[SA_PAGE], addr_q[BYTE_W-1:0]}; // RULE_10 RULE_13
              drv_d = 1'b1; // RULE_05 RULE_21
            end else begin
              st_d = ST_IGNORE; // RULE_25
            end
          end else if (at_ack) begin
            if (rw_q) begin
              st_d = ST_READ;
              tx_d = rd_word;
              drv_d = ~rd_word[BYTE_W-1]; // RULE_19
            end else begin
              st_d = ST_WORD;
            end
          end
        end
        ST_WORD: begin
          if (at_last) begin
            addr_d = {addr_q[ADDR_W-1], rx_byte}; // RULE_12
            drv_d = 1'b1; // RULE_05
          end else if (at_ack) begin
            st_d = ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (at_last) begin
            if (!wp_s) begin
              wr_en = 1'b1; // RULE_20
              addr_d = addr_inc; // RULE_14
              drv_d = 1'b1; // RULE_18
              ack_d = 1'b1;
            end else begin
              ack_d = 1'b0; // RULE_22 RULE_23
            end
          end else if (at_ack && !ack_q) begin
            st_d = ST_IGNORE; // RULE_06
          end
        end
        ST_READ: begin
          if (at_last) begin
            addr_d = addr_inc; // RULE_14
          end else if (at_ack) begin
            if (sda_s) begin
              st_d = ST_IGNORE; // RULE_06 RULE_17
            end else begin
              tx_d = rd_word; // RULE_07 RULE_17
              drv_d = ~rd_word[BYTE_W-1];
            end
          end else begin
            tx_d = {tx_q[BYTE_W-2:0], 1'b0}; // RULE_19
            drv_d = ~tx_q[BYTE_W-2];
          end
        end
        ST_IDLE, ST_IGNORE: begin
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_IDLE; // RULE_26
      cnt_q <= CNT_ZERO;
      rx_q <= '0;
      tx_q <= '0;
      addr_q <= ADDR_RST; // RULE_26
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      drv_q <= drv_d;
    end
  end

  // primed marks that the link stage has seen a falling edge since reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      primed_q <= 1'b0;
    end else if (fall_det) begin
      primed_q <= 1'b1;
    end
  end

  // no reset on the array: contents survive reset like the real cells
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[addr_q] <= rx_byte; // RULE_20
    end
  end

  // link stage on the bus clock. drv_q is set only just after a rising
  // edge (start and stop merely clear it), so it is a half bus period stable before this falling edge;
  // the sync delay of the system side must stay well below that half.
  logic drv_link_q;

  always_ff @(negedge scl) begin
    drv_link_q <= drv_q; // RULE_24
  end

  // dropping st_active releases the line at once on stop, mismatch or nack; a start keeps st_active
  assign sda_o = 1'b0;
  assign sda_oe_n = ~(drv_link_q & st_active & primed_q); // RULE_25 RULE_26

  // checks on the system clock side
  a_stop_to_idle: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (rst)
    stop_det |=> (st_q == ST_IDLE) && sda_oe_n)
    else $error("stop did not return slave to idle");

  a_start_restart: assert property ( // RULE_02
    @(posedge sys_clk) disable iff (rst)
    start_det && !stop_det |=> (st_q == ST_SLAVE) && (cnt_q == CNT_ZERO))
    else $error("start did not restart address phase");

  a_addr_mismatch: assert property ( // RULE_25
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_SLAVE) && at_last
      && !dev_match
    |=> (st_q == ST_IGNORE) && !drv_q ##1 sda_oe_n)
    else $error("mismatched address not ignored");

  a_page_select: assert property ( // RULE_10
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_SLAVE) && at_last
      && dev_match
    |=> drv_q && (addr_q[ADDR_W-1] == $past(rx_q[SA_PAGE - 1])))
    else $error("page bit not taken from slave address");

  a_word_ack: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_WORD) && at_last
    |=> drv_q && (cnt_q == CNT_ACK) && (addr_q[BYTE_W-1:0] == $past(rx_byte)))
    else $error("word address not latched and acknowledged");

  a_wp_blocks: assert property ( // RULE_22
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_WRITE) && at_last
      && wp_s
    |=> !drv_q && (addr_q == $past(addr_q)) && !ack_q)
    else $error("protected write was acknowledged or advanced");

  a_write_incr: assert property ( // RULE_14
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_WRITE) && at_last
      && !wp_s
    |=> drv_q && (addr_q == (($past(addr_q) == ADDR_TOP) ? ADDR_RST
                              : $past(addr_q) + ADDR_ONE)))
    else $error("write address did not advance or wrap");

  a_read_nack: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_READ) && at_ack
      && sda_s
    |=> (st_q == ST_IGNORE) ##1 sda_oe_n [*2])
    else $error("read not ended by missing acknowledge");

  a_read_release: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_READ) && at_last
    |=> !drv_q && (cnt_q == CNT_ACK))
    else $error("line not released for master acknowledge");

  a_idle_quiet: assert property ( // RULE_26
    @(posedge sys_clk) disable iff (rst)
    (st_q == ST_IDLE) && $past(st_q == ST_IDLE) |-> sda_oe_n && !wr_en)
    else $error("idle slave touched the bus or array");

  a_dir_latch: assert property ( // RULE_11
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_SLAVE) && at_last
      && dev_match
    |=> (rw_q == $past(rx_byte[SA_RW])))
    else $error("direction bit not taken from slave address");

  a_read_first: assert property ( // RULE_13
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_SLAVE) && at_ack
      && rw_q
    |=> (st_q == ST_READ) && (tx_q == $past(rd_word))
      && (drv_q == !$past(rd_word[BYTE_W-1])))
    else $error("read did not start from latched address");

  a_read_next: assert property ( // RULE_07
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && (st_q == ST_READ) && at_ack
      && !sda_s
    |=> (st_q == ST_READ) && (tx_q == $past(rd_word)))
    else $error("acknowledged read did not load next byte");

  a_ack_drop: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (rst)
    rise_det && !start_det && !stop_det && at_ack
      && ((st_q == ST_WORD) || (st_q == ST_WRITE))
    |=> !drv_q)
    else $error("line not released after write acknowledge");

  a_array_write: assert property ( // RULE_20
    @(posedge sys_clk) disable iff (rst)
    wr_en |=> (mem[$past(addr_q)] == $past(rx_byte)))
    else $error("data byte not stored in array");

  // deliberately not disabled by reset: it checks the reset itself
  a_reset_idle: assert property ( // RULE_26
    @(posedge sys_clk)
    rst |=> (st_q == ST_IDLE) && (addr_q == ADDR_RST) && sda_oe_n)
    else $error("reset did not leave slave idle at location zero");

endmodule : snv_slave

//--- dv/snv_master.sv
// behavioural two-wire bus master facing the nvram slave
module snv_master (
  // bus lines; the clock stands still between frames
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data only moves while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
    #16;
  endtask : bit_x

  task automatic start_c();
    sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask : start_c

  // only called after a nack, an ack slot or a partial write byte, so the master owns the line
  task automatic stop_c();
    sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #32;
  endtask : stop_c

  // ack_in high leaves the ack slot released
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], rd[i]);
    end
    bit_x(ack_in, ack);
  endtask : xfer

  // short byte, used to abort a write before its last bit
  task automatic partial(input int n);
    logic r;
    for (int i = 0; i < n; i++) begin
      bit_x(1'b0, r);
    end
  endtask : partial
endmodule : snv_master

//--- dv/test_snv_slave.sv
// self-checking bench for the two-wire nvram slave
module test_snv_slave;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] TYPE = 4'h5;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_hi = 1'b0;
  logic cs_lo = 1'b0;
  logic wp = 1'b0;
  logic scl, m_low, sda_o, sda_oe_n, ak;
  logic [7:0] rd;
  wire sda;
  int fails = 0;
  int n_checks = 0;

  always #2 sys_clk = ~sys_clk;
  // open drain line with pull-up
  assign sda = ~(m_low | (~sda_oe_n & ~sda_o));

  snv_slave #(.DEV_TYPE(TYPE)) i_snv_slave (.sys_clk(sys_clk), .rst(rst),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .chip_select_strap_high(cs_hi), .chip_select_strap_low(cs_lo),
    .write_protect(wp));
  snv_master i_snv_master (.scl(scl), .sda_low(m_low), .sda(sda));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_ack(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_ack

  function automatic logic [7:0] sa(input logic pg, input logic rw);
    return {TYPE, cs_hi, cs_lo, pg, rw};
  endfunction : sa

  task automatic send(input logic [7:0] d, input logic exp);
    i_snv_master.xfer(d, 1'b1, rd, ak);
    chk_ack(ak, exp);
  endtask : send

  task automatic get(input logic last, input logic [7:0] exp);
    i_snv_master.xfer(8'hFF, last, rd, ak);
    chk_byte(rd, exp);
  endtask : get

  task automatic seek(input logic pg, input logic [7:0] a);
    i_snv_master.start_c();
    send(sa(pg, 1'b0), 1'b0);
    send(a, 1'b0);
  endtask : seek

  task automatic rd_start(input logic pg);
    i_snv_master.start_c();
    send(sa(pg, 1'b1), 1'b0);
  endtask : rd_start

  task automatic t_wrap();
    @(negedge sys_clk) cs_hi = 1'b1;
    seek(1'b1, 8'hFF);
    send(8'hA5, 1'b0);
    send(8'h3C, 1'b0);
    send(8'hC3, 1'b0);
    i_snv_master.stop_c();
    seek(1'b1, 8'hFF);
    rd_start(1'b1);
    get(1'b0, 8'hA5);
    get(1'b0, 8'h3C);
    get(1'b1, 8'hC3);
    chk_ack(sda_oe_n, 1'b1);
    i_snv_master.stop_c();
    $display("test wrap done");
  endtask : t_wrap

  task automatic t_miss();
    logic [7:0] bad [3];
    bad = '{{~TYPE, cs_hi, cs_lo, 2'b00}, {TYPE, ~cs_hi, cs_lo, 2'b00},
            {TYPE, cs_hi, ~cs_lo, 2'b01}};
    foreach (bad[i]) begin
      i_snv_master.start_c();
      send(bad[i], 1'b1);
      send(8'h00, 1'b1);
      i_snv_master.stop_c();
    end
    $display("test miss done");
  endtask : t_miss

  task automatic t_protect();
    // both straps high from here on, so a match on a high low strap is seen
    @(negedge sys_clk) cs_lo = 1'b1;
    seek(1'b0, 8'h10);
    send(8'h77, 1'b0);
    i_snv_master.stop_c();
    @(negedge sys_clk) wp = 1'b1;
    seek(1'b0, 8'h10);
    send(8'h11, 1'b1);
    i_snv_master.stop_c();
    @(negedge sys_clk) wp = 1'b0;
    rd_start(1'b0);
    get(1'b1, 8'h77);
    i_snv_master.stop_c();
    $display("test protect done");
  endtask : t_protect

  task automatic t_abort();
    seek(1'b0, 8'h20);
    send(8'h66, 1'b0);
    seek(1'b0, 8'h20);
    i_snv_master.partial(5);
    i_snv_master.stop_c();
    seek(1'b0, 8'h20);
    // the start's own clock rise is the seventh, still short of a byte
    i_snv_master.partial(6);
    rd_start(1'b0);
    get(1'b1, 8'h66);
    i_snv_master.stop_c();
    $display("test abort done");
  endtask : t_abort

  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk_ack(sda_oe_n, 1'b1);
    $display("test reset done");
    t_wrap();
    t_miss();
    t_protect();
    t_abort();
    complete_run();
  end

  // cuts a hang short
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
endmodule : test_snv_slave
